// ---- rtl/half_duplex_async_serial_port.sv ----
// half duplex asynchronous serial port with byte register bank
// How it works
// - direction bit 0 of mode register 0: 0 transmits, 1 receives
// - run bit starts; transmit clears it at end, receive runs until software clears
// - clock select bit 2 picks low speed clock when 0, high speed when 1
// - receive pin select bit 4 picks primary pin when 0, alternate when 1
// - length field 00/01/10/11 gives 8/7/6/5 data bits
// - parity field: 00 even, 01 odd, upper bit 1 omits parity
// - stop length bit 4: one stop bit when 0, two when 1
// - polarity bit 5 inverts both transmit and receive lines when 1
// - bit order bit 6: lsb first when 0, msb first when 1
// - 12-bit baud count from low byte and high nibble, reset 0ffh and 0fh
// - receive mode ignores buffer writes; each reception loads the buffer
// - unused upper bits ignored on transmit, stored as zero on receive
// - transmit mode buffer reads back what was written
// - any write to the flag register clears all flags, unless a reception completes in that cycle
// - framing error on bad start or stop, re-evaluated each reception
// - overrun when a new character arrives before the old one was read
// - unread tracking survives stopping and restarting reception
// - parity error when received parity disagrees, updated each character
// - error flags stay zero in transmit mode
// - buffer full set by transmit write, cleared on move to shifter, zero in receive
// - baud count at or below seven reads back but acts as eight
// - no queued character at stop end: finish stop, clear run, request interrupt
`timescale 1ns/10ps
module half_duplex_async_serial_port
   import serial_pkg::*;
(
   input  wire logic                          CLOCK_I,  // 25 mhz system clock
   input  wire logic                          RST_N_I,  // async reset, active low
   input  wire logic [serial_pkg::ADDR_W-1:0] ADDR_I,   // register byte address
   input  wire logic [serial_pkg::DATA_W-1:0] WDATA_I,  // write data
   input  wire logic                          WR_I,     // write strobe
   input  wire logic                          RD_I,     // read strobe
   output logic      [serial_pkg::DATA_W-1:0] RDATA_O,  // read data, cycle after strobe
   input  wire logic                          LOW_SPEED_CLOCK_I,  // slow baud source
   input  wire logic                          HIGH_SPEED_CLOCK_I, // fast baud source
   input  wire logic                          PRIMARY_INPUT_PIN_I,   // receive pin 0
   input  wire logic                          ALTERNATE_INPUT_PIN_I, // receive pin 1
   output logic                               SERIAL_OUT_PIN_O,      // transmit line
   output logic                               IRQ_O     // one-cycle event pulse
);
   import serial_pkg::*;

   // configuration and status registers
   logic             run_q;
   logic [7:0]       md0_q;
   logic [7:0]       md1_q;
   logic [7:0]       brtl_q;
   logic [3:0]       brth_q;
   logic [7:0]       buf_q;
   logic             full_q;
   logic             fer_q;
   logic             oer_q;
   logic             per_q;
   logic             unread_q;

   // frame sequencer
   state_e           state_q;
   logic [2:0]       bitcnt_q;
   logic [7:0]       sh_q;
   logic             par_q;
   logic             fe_q;
   logic             pe_q;

   // pin synchronisers: stage one feeds only stage two
   logic [3:0]       meta_q;
   logic [3:0]       sync_q;
   logic [1:0]       ck_prev_q;

   // decoded controls and events
   logic             is_rx;
   logic             two_stop;
   logic             par_off;
   logic             par_odd;
   logic             neg;
   logic             msb_first;
   logic [1:0]       len;
   logic [7:0]       len_mask;
   logic             rx_lvl;
   logic             src_tick;
   logic             bit_tick;
   logic             mid_tick;
   logic             step;
   logic             last_bit;
   logic             at_end;
   logic             start_tx;
   logic             start_rx;
   logic             tx_load;
   logic             tx_end;
   logic             rx_done;
   logic             tx_bit;
   logic [7:0]       rx_data;
   logic             wr_buf;
   logic             wr_stat;

   // field decode
   assign is_rx     = md0_q[MD0_DIR];
   assign len       = md1_q[MD1_LEN +: 2];
   assign len_mask  = ALL_ONES >> len;
   assign par_off   = md1_q[MD1_POFF];
   assign par_odd   = md1_q[MD1_PODD];
   assign two_stop  = md1_q[MD1_STOP];
   assign neg       = md1_q[MD1_NEG];
   assign msb_first = md1_q[MD1_MSB];
   assign wr_buf    = WR_I && (ADDR_I == ADDR_BUF);
   assign wr_stat   = WR_I && (ADDR_I == ADDR_STAT);

   // pins and baud sources come from outside, two flops before use
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         meta_q    <= 4'hf;
         sync_q    <= 4'hf;
         ck_prev_q <= 2'h3;
      end else begin
         meta_q    <= {LOW_SPEED_CLOCK_I, HIGH_SPEED_CLOCK_I,
                       PRIMARY_INPUT_PIN_I, ALTERNATE_INPUT_PIN_I};
         sync_q    <= meta_q;
         ck_prev_q <= sync_q[3:2];
      end
   end

   // source edge and logical receive level after polarity
   assign src_tick = md0_q[MD0_CKHI] ? (sync_q[2] && !ck_prev_q[0])
                                     : (sync_q[3] && !ck_prev_q[1]);
   assign rx_lvl   = (md0_q[MD0_RSEL] ? sync_q[0] : sync_q[1]) ^ neg;

   // generator is held cleared while idle so each frame starts a fresh period
   baud_gen u_baud (
      .clk_i   (CLOCK_I),
      .rst_n_i (RST_N_I),
      .clear_i (state_q == S_IDLE),
      .tick_i  (src_tick),
      .count_i ({brth_q, brtl_q}),
      .bit_o   (bit_tick),
      .mid_o   (mid_tick)
   );

   // transmit steps on period ends, receive samples at mid bit
   assign step     = is_rx ? mid_tick : bit_tick;
   assign last_bit = (bitcnt_q == (LAST_BIT - {1'b0, len}));
   assign at_end   = step && (((state_q == S_STOP1) && !two_stop) ||
                              (state_q == S_STOP2));
   assign start_tx = (state_q == S_IDLE) && run_q && !is_rx;
   assign start_rx = (state_q == S_IDLE) && run_q && is_rx && !rx_lvl;
   assign tx_load  = start_tx || (at_end && !is_rx && full_q);
   assign tx_end   = at_end && !is_rx && !full_q;
   assign rx_done  = at_end && is_rx;

   // received word right-aligned, upper unused bits zero
   assign rx_data  = msb_first ? (sh_q & len_mask) : (sh_q >> len);

   // line bit for the current transmit state
   always_comb begin
      case (state_q)
         S_START: tx_bit = 1'b0;
         S_DATA:  tx_bit = msb_first ? sh_q[7] : sh_q[0];
         S_PAR:   tx_bit = par_q;
         default: tx_bit = 1'b1;
      endcase
   end

   // frame sequencer shared by both directions
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q  <= S_IDLE;
         bitcnt_q <= '0;
         sh_q     <= '0;
         par_q    <= 1'b0;
         fe_q     <= 1'b0;
         pe_q     <= 1'b0;
      end else if (!run_q) begin
         state_q  <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (start_tx || start_rx) begin
                  state_q <= S_START;
               end
               if (start_rx) begin
                  par_q <= par_odd;
                  fe_q  <= 1'b0;
                  pe_q  <= 1'b0;
               end
            end
            S_START: begin
               if (step) begin
                  state_q  <= S_DATA;
                  bitcnt_q <= '0;
                  if (is_rx) begin
                     fe_q <= rx_lvl;
                  end
               end
            end
            S_DATA: begin
               if (step) begin
                  bitcnt_q <= bitcnt_q + 3'h1;
                  if (is_rx) begin
                     sh_q  <= msb_first ? {sh_q[6:0], rx_lvl} : {rx_lvl, sh_q[7:1]};
                     par_q <= par_q ^ rx_lvl;
                  end else begin
                     sh_q  <= msb_first ? (sh_q << 1) : (sh_q >> 1);
                  end
                  if (last_bit) begin
                     state_q <= par_off ? S_STOP1 : S_PAR;
                  end
               end
            end
            S_PAR: begin
               if (step) begin
                  state_q <= S_STOP1;
                  if (is_rx) begin
                     pe_q <= rx_lvl ^ par_q;
                  end
               end
            end
            S_STOP1, S_STOP2: begin
               if (step) begin
                  if (is_rx && !rx_lvl) begin
                     fe_q <= 1'b1;
                  end
                  if (state_q == S_STOP1 && two_stop) begin
                     state_q <= S_STOP2;
                  end else begin
                     state_q <= tx_load ? S_START : S_IDLE;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
         // move queued character into the shifter, upper unused bits never sent
         if (tx_load) begin
            sh_q  <= msb_first ? (buf_q << len) : buf_q;
            par_q <= (^(buf_q & len_mask)) ^ par_odd;
         end
      end
   end

   // run bit: software write wins over the end-of-transmit clear
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         run_q <= 1'b0;
      end else if (WR_I && ADDR_I == ADDR_CON) begin
         run_q <= WDATA_I[CON_RUN];
      end else if (tx_end) begin
         run_q <= 1'b0;
      end
   end

   // mode and baud registers; only masked bits are kept, so mode register 0 also keeps unused bit 1
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         md0_q  <= MD_RST;
         md1_q  <= MD_RST;
         brtl_q <= BRTL_RST;
         brth_q <= BRTH_RST;
      end else if (WR_I) begin
         case (ADDR_I)
            ADDR_MD0:  md0_q  <= WDATA_I & MD0_MASK;
            ADDR_MD1:  md1_q  <= WDATA_I & MD1_MASK;
            ADDR_BRTL: brtl_q <= WDATA_I;
            ADDR_BRTH: brth_q <= WDATA_I[3:0];
            default:   ;
         endcase
      end
   end

   // data buffer: reception overwrites, software writes only in transmit mode
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         buf_q <= BUF_RST;
      end else if (rx_done) begin
         buf_q <= rx_data;
      end else if (wr_buf && !is_rx) begin
         buf_q <= WDATA_I;
      end
   end

   // buffer full: a write sets it even if the old character loads the same cycle
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         full_q <= 1'b0;
      end else if (is_rx) begin
         full_q <= 1'b0;
      end else if (wr_buf) begin
         full_q <= 1'b1;
      end else if (tx_load || wr_stat) begin
         full_q <= 1'b0;
      end
   end

   // unread marker is not touched by run, so it survives a restart
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         unread_q <= 1'b0;
      end else if (rx_done) begin
         unread_q <= 1'b1;
      end else if (RD_I && ADDR_I == ADDR_BUF) begin
         unread_q <= 1'b0;
      end
   end

   // error flags: a completing reception wins over a clearing write
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fer_q <= 1'b0;
         oer_q <= 1'b0;
         per_q <= 1'b0;
      end else if (!is_rx) begin
         fer_q <= 1'b0;
         oer_q <= 1'b0;
         per_q <= 1'b0;
      end else if (rx_done) begin
         fer_q <= fe_q || !rx_lvl;
         oer_q <= unread_q || (oer_q && !wr_stat);
         per_q <= pe_q && !par_off;
      end else if (wr_stat) begin
         fer_q <= 1'b0;
         oer_q <= 1'b0;
         per_q <= 1'b0;
      end
   end

   // read data only in the cycle after the strobe, zero otherwise
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RDATA_O <= '0;
      end else if (RD_I) begin
         case (ADDR_I)
            ADDR_BUF:  RDATA_O <= buf_q;
            ADDR_CON:  RDATA_O <= {7'h00, run_q};
            ADDR_MD0:  RDATA_O <= md0_q;
            ADDR_MD1:  RDATA_O <= md1_q;
            ADDR_BRTL: RDATA_O <= brtl_q;
            ADDR_BRTH: RDATA_O <= {4'h0, brth_q};
            ADDR_STAT: RDATA_O <= {4'h0, full_q, per_q, oer_q, fer_q};
            default:   RDATA_O <= '0;
         endcase
      end else begin
         RDATA_O <= '0;
      end
   end

   // line driven from a flop; receive mode holds it high
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SERIAL_OUT_PIN_O <= 1'b1;
      end else begin
         SERIAL_OUT_PIN_O <= is_rx ? 1'b1 : (tx_bit ^ neg);
      end
   end

   // one pulse per start bit sent, transmit finish, or character received
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= tx_load || tx_end || rx_done;
      end
   end
endmodule

// ---- rtl/serial_pkg.sv ----
// shared constants for the half duplex serial port
package serial_pkg;
   // bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 12;

   // register byte addresses
   localparam logic [15:0] ADDR_BUF  = 16'hf290;
   localparam logic [15:0] ADDR_CON  = 16'hf291;
   localparam logic [15:0] ADDR_MD0  = 16'hf292;
   localparam logic [15:0] ADDR_MD1  = 16'hf293;
   localparam logic [15:0] ADDR_BRTL = 16'hf294;
   localparam logic [15:0] ADDR_BRTH = 16'hf295;
   localparam logic [15:0] ADDR_STAT = 16'hf296;

   // run control field
   localparam int CON_RUN = 0;

   // direction, clock and receive pin select register fields
   localparam int MD0_DIR  = 0;
   localparam int MD0_CKHI = 2;
   localparam int MD0_RSEL = 4;
   localparam logic [7:0] MD0_MASK = 8'h17;

   // frame format register fields
   localparam int MD1_LEN  = 0;
   localparam int MD1_PODD = 2;
   localparam int MD1_POFF = 3;
   localparam int MD1_STOP = 4;
   localparam int MD1_NEG  = 5;
   localparam int MD1_MSB  = 6;
   localparam logic [7:0] MD1_MASK = 8'h7f;

   // flag register fields
   localparam int ST_FER = 0;
   localparam int ST_OER = 1;
   localparam int ST_PER = 2;
   localparam int ST_FUL = 3;

   // reset values
   localparam logic [7:0] MD_RST   = 8'h00;
   localparam logic [7:0] BRTL_RST = 8'hff;
   localparam logic [3:0] BRTH_RST = 4'hf;
   localparam logic [7:0] BUF_RST  = 8'h00;

   // smallest count the generator honours, and the last data bit index of 8
   localparam logic [CNT_W-1:0] BRT_MIN  = 12'h008;
   localparam logic [2:0]       LAST_BIT = 3'h7;
   localparam logic [7:0]       ALL_ONES = 8'hff;

   // frame sequencer states, shared by transmit and receive
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP1, S_STOP2} state_e;
endpackage

// ---- rtl/baud_gen.sv ----
// baud generator: divides the selected source clock edges into bit periods
`timescale 1ns/10ps
module baud_gen
   import serial_pkg::*;
(
   input  wire logic             clk_i,   // system clock
   input  wire logic             rst_n_i, // async reset, active low
   input  wire logic             clear_i, // hold counter at zero
   input  wire logic             tick_i,  // one source clock edge
   input  wire logic [CNT_W-1:0] count_i, // programmed count
   output logic                  bit_o,   // pulse at end of each bit period
   output logic                  mid_o    // pulse at middle of each bit period
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] eff;

   // counts below the minimum behave as the minimum, the register keeps the value
   assign eff = (count_i < BRT_MIN) ? BRT_MIN : count_i;

   // a period is count plus one source edges
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
         bit_o <= 1'b0;
         mid_o <= 1'b0;
      end else if (clear_i) begin
         cnt_q <= '0;
         bit_o <= 1'b0;
         mid_o <= 1'b0;
      end else begin
         bit_o <= tick_i && (cnt_q == eff);
         mid_o <= tick_i && (cnt_q == (eff >> 1));
         if (tick_i) begin
            if (cnt_q == eff) begin
               cnt_q <= '0;
            end else begin
               cnt_q <= cnt_q + 12'h001;
            end
         end
      end
   end
endmodule

// ---- test/serial_port_checker.sv ----
// concurrent checks on the serial port register bank, line and event pulse
`timescale 1ns/10ps
module serial_port_checker
   import serial_pkg::*;
(
   input wire logic                          CLOCK_I,          // system clock
   input wire logic                          RST_N_I,          // async reset, active low
   input wire logic [serial_pkg::ADDR_W-1:0] ADDR_I,           // register address
   input wire logic [serial_pkg::DATA_W-1:0] WDATA_I,          // write data
   input wire logic                          WR_I,             // write strobe
   input wire logic                          RD_I,             // read strobe
   input wire logic [serial_pkg::DATA_W-1:0] RDATA_O,          // read data
   input wire logic                          SERIAL_OUT_PIN_O, // transmit line
   input wire logic                          IRQ_O             // event pulse
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   // shadow of the direction bit; good enough since mode changes only while stopped
   logic rx_mode_q;
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rx_mode_q <= 1'b0;
      end else if (WR_I && ADDR_I == ADDR_MD0) begin
         rx_mode_q <= WDATA_I[MD0_DIR];
      end
   end

   // write followed at once by a read of the same place
   sequence baud_wr_rd;
      (WR_I && ADDR_I == ADDR_BRTL) ##1 (RD_I && ADDR_I == ADDR_BRTL);
   endsequence
   sequence buf_wr_rd;
      (WR_I && ADDR_I == ADDR_BUF && !rx_mode_q) ##1 (RD_I && ADDR_I == ADDR_BUF);
   endsequence
   sequence stat_wr_rd;
      (WR_I && ADDR_I == ADDR_STAT) ##1 (RD_I && ADDR_I == ADDR_STAT && !IRQ_O);
   endsequence

   unmapped_read_a:
      assert property ((RD_I && (ADDR_I < ADDR_BUF || ADDR_I > ADDR_STAT)) |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   run_upper_a:
      assert property ((RD_I && ADDR_I == ADDR_CON) |=> RDATA_O[7:1] == 7'h00)
      else $error("run register upper bits set");
   mode_bits_a:
      assert property ((RD_I && ADDR_I == ADDR_MD0) |=> (RDATA_O & ~MD0_MASK) == 8'h00)
      else $error("mode register unused bits set");
   baud_readback_a:
      assert property (baud_wr_rd |=> RDATA_O == $past(WDATA_I, 2))
      else $error("baud count readback differs");
   tx_readback_a:
      assert property (buf_wr_rd |=> RDATA_O == $past(WDATA_I, 2))
      else $error("transmit buffer readback differs");
   flag_clear_a:
      assert property (stat_wr_rd |=> RDATA_O == 8'h00)
      else $error("flags not cleared by write");
   tx_no_errors_a:
      assert property ((RD_I && ADDR_I == ADDR_STAT && !rx_mode_q) |=> RDATA_O[2:0] == 3'h0)
      else $error("error flag set in transmit mode");
   rx_no_full_a:
      assert property ((RD_I && ADDR_I == ADDR_STAT && rx_mode_q) |=> !RDATA_O[ST_FUL])
      else $error("full flag set in receive mode");
   rx_line_idle_a:
      assert property (rx_mode_q && $past(rx_mode_q, 3) |-> SERIAL_OUT_PIN_O)
      else $error("transmit line low in receive mode");
   irq_pulse_a:
      assert property ($rose(IRQ_O) |=> !IRQ_O)
      else $error("event pulse longer than one cycle");
endmodule

bind half_duplex_async_serial_port serial_port_checker u_checker (
   .CLOCK_I(CLOCK_I),
   .RST_N_I(RST_N_I),
   .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I),
   .WR_I(WR_I),
   .RD_I(RD_I),
   .RDATA_O(RDATA_O),
   .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O),
   .IRQ_O(IRQ_O)
);

// ---- test/serial_remote.sv ----
// remote serial partner: drives both receive pins and samples the transmit line
`timescale 1ns/10ps
module serial_remote (
   input  wire logic tx_line_i, // device transmit line
   output logic      pin_a_o,   // device primary receive pin
   output logic      pin_b_o    // device alternate receive pin
);
   logic idle_q = 1'b1;
   initial begin
      pin_a_o = 1'b1;
      pin_b_o = 1'b1;
   end

   // idle level follows the chosen polarity
   task automatic set_idle(input logic neg);
      idle_q = ~neg;
      pin_a_o <= ~neg;
      pin_b_o <= ~neg;
   endtask

   // the unused pin carries the inverse, so listening to the wrong pin shows up
   task automatic send(input logic alt, input logic [12:0] f, input int nb, input int per);
      for (int i = 0; i < nb; i++) begin
         pin_a_o <= alt ? ~f[i] : f[i];
         pin_b_o <= alt ? f[i] : ~f[i];
         #per;
      end
      pin_a_o <= idle_q;
      pin_b_o <= idle_q;
   endtask

   // wait for the start level, then sample each bit in its middle
   task automatic grab(input logic neg, input int nb, input int per, output logic [12:0] f);
      f = 13'h1fff ^ {13{neg}};
      wait (tx_line_i === neg);
      #(per / 2);
      for (int i = 0; i < nb; i++) begin
         f[i] = tx_line_i;
         #per;
      end
   endtask
endmodule

// ---- test/half_duplex_async_serial_port_tb.sv ----
// self-checking bench for the half duplex serial port
`timescale 1ns/10ps
module half_duplex_async_serial_port_tb;
   import serial_pkg::*;
`define CHK(got, want) begin n_compared++; if ((got) !== (want)) begin num_errors++; \
   $display("mismatch at %0t: got %h want %h", $time, got, want); end end

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        ls_clk = 1'b0;
   logic        hs_clk = 1'b0;
   logic [7:0]  rdata;
   logic        pin_a;
   logic        pin_b;
   logic        tx_line;
   logic        irq;
   int          num_errors = 0;
   int          n_compared = 0;
   int          irq_count = 0;

   // odd half periods let only every 20th edge of each baud source land on a system clock edge
   always #20 clk = ~clk;
   always #81 hs_clk = ~hs_clk;
   always #203 ls_clk = ~ls_clk;
   always @(posedge clk) begin
      if (irq === 1'b1) irq_count++;
   end

   half_duplex_async_serial_port DUT (
      .CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .LOW_SPEED_CLOCK_I(ls_clk), .HIGH_SPEED_CLOCK_I(hs_clk),
      .PRIMARY_INPUT_PIN_I(pin_a), .ALTERNATE_INPUT_PIN_I(pin_b),
      .SERIAL_OUT_PIN_O(tx_line), .IRQ_O(irq));
   serial_remote u_far (.tx_line_i(tx_line), .pin_a_o(pin_a), .pin_b_o(pin_b));

   // bus tasks start right after a rising edge; a write leaves its strobe up
   task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic bus_idle();
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk_reg(input logic [15:0] a, input logic [7:0] want);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      `CHK(rdata, want)
      @(posedge clk);
   endtask

   // line levels of one frame, start bit first; returns the bit count
   function automatic int frame(input logic [7:0] md1, input logic [7:0] d,
                                output logic [12:0] f);
      int n;
      int k;
      logic p;
      n = 8 - int'(md1[1:0]);
      f = 13'h1fff;
      f[0] = 1'b0;
      p = md1[MD1_PODD];
      for (k = 0; k < n; k++) begin
         f[k + 1] = md1[MD1_MSB] ? d[n - 1 - k] : d[k];
         p = p ^ d[k];
      end
      k = n + 1;
      if (!md1[MD1_POFF]) begin
         f[k] = p;
         k++;
      end
      f = f ^ {13{md1[MD1_NEG]}};
      return k + 1 + int'(md1[MD1_STOP]);
   endfunction

   // reset values, unused bits, unmapped place, short baud count
   task automatic t_regs();
      logic [7:0] tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h0f, 8'h00};
      for (int i = 0; i < 7; i++) chk_reg(ADDR_BUF + 16'(i), tab[i]);
      chk_reg(16'hf297, 8'h00);
      bus_wr(ADDR_MD0, 8'hff);
      chk_reg(ADDR_MD0, MD0_MASK);
      bus_wr(ADDR_MD1, 8'hff);
      chk_reg(ADDR_MD1, MD1_MASK);
      bus_wr(ADDR_BRTH, 8'hff);
      chk_reg(ADDR_BRTH, 8'h0f);
      bus_wr(ADDR_CON, 8'hfe);
      chk_reg(ADDR_CON, 8'h00);
      bus_wr(ADDR_BRTH, 8'h00);
      bus_wr(ADDR_BRTL, 8'h03);
      chk_reg(ADDR_BRTL, 8'h03);
   endtask

   // one transmitted frame; count 3 must time like 8, so a bit is 9 source periods
   task automatic t_tx(input logic [7:0] md0, input logic [7:0] md1, input logic [7:0] d);
      logic [12:0] want;
      logic [12:0] got;
      int nb;
      nb = frame(md1, d, want);
      bus_wr(ADDR_MD0, md0);
      bus_wr(ADDR_MD1, md1);
      bus_wr(ADDR_BUF, d);
      chk_reg(ADDR_BUF, d);
      chk_reg(ADDR_STAT, 8'h08);
      irq_count = 0;
      bus_wr(ADDR_CON, 8'h01);
      bus_idle();
      u_far.grab(md1[MD1_NEG], nb, md0[MD0_CKHI] ? 9 * 162 : 9 * 406, got);
      @(posedge clk);
      `CHK(got, want)
      chk_reg(ADDR_CON, 8'h00);
      chk_reg(ADDR_STAT, 8'h00);
      `CHK(irq_count, 2)
   endtask

   // one received frame with optional corrupted bits, then flags and buffer
   task automatic t_rx(input logic alt, input logic [7:0] md1, input logic [7:0] d,
                       input logic [12:0] flip, input logic [7:0] st, input logic rd_buf);
      logic [12:0] f;
      int nb;
      nb = frame(md1, d, f);
      irq_count = 0;
      // drop a write strobe left up by the caller before the frame goes out
      bus_idle();
      u_far.send(alt, f ^ flip, nb, 9 * 162);
      @(posedge clk);
      chk_reg(ADDR_STAT, st);
      `CHK(irq_count, 1)
      if (rd_buf) chk_reg(ADDR_BUF, d & (8'hff >> md1[1:0]));
   endtask

   task automatic wrap_up();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_tx(8'h04, 8'h00, 8'ha5);
      t_tx(8'h04, 8'h45, 8'h5a);
      t_tx(8'h02, 8'h3b, 8'h3c);
      // receive on the primary pin, positive logic
      bus_wr(ADDR_MD1, 8'h00);
      bus_wr(ADDR_BUF, 8'h3c);
      u_far.set_idle(1'b0);
      bus_wr(ADDR_MD0, 8'h05);
      bus_wr(ADDR_CON, 8'h01);
      bus_wr(ADDR_BUF, 8'h77);
      chk_reg(ADDR_BUF, 8'h3c);
      t_rx(1'b0, 8'h00, 8'ha5, 13'h0000, 8'h00, 1'b1);
      t_rx(1'b0, 8'h00, 8'h96, 13'h0000, 8'h00, 1'b0);
      bus_wr(ADDR_CON, 8'h00);
      bus_wr(ADDR_CON, 8'h01);
      t_rx(1'b0, 8'h00, 8'h3c, 13'h0200, 8'h06, 1'b1);
      chk_reg(ADDR_CON, 8'h01);
      bus_wr(ADDR_STAT, 8'h5a);
      chk_reg(ADDR_STAT, 8'h00);
      // alternate pin, inverted, msb first, 7 bits odd parity
      bus_wr(ADDR_CON, 8'h00);
      bus_wr(ADDR_MD1, 8'h65);
      u_far.set_idle(1'b1);
      bus_wr(ADDR_MD0, 8'h15);
      bus_wr(ADDR_CON, 8'h01);
      t_rx(1'b1, 8'h65, 8'hff, 13'h0000, 8'h00, 1'b1);
      t_rx(1'b1, 8'h65, 8'h2b, 13'h0200, 8'h01, 1'b1);
      bus_wr(ADDR_CON, 8'h00);
      // the framing error left above must vanish once transmit mode is back
      bus_wr(ADDR_MD0, 8'h00);
      bus_idle();
      chk_reg(ADDR_STAT, 8'h00);
      wrap_up();
   end

   // cut a hang short well past the expected run length
   initial begin
      #1_000_000;
      num_errors++;
      wrap_up();
   end
endmodule
